// File: hdl/pss_pkg.sv
// Constants for the clock source and multiplier boot selection block.
// Assumes one 250 MHz system clock and a 24-bit multiplexed host bus.
package pss_pkg;

    localparam int          BUS_W        = 24;
    localparam int          BOOT_W       = 6;
    localparam int          MULT_LSB     = 0;
    localparam int          MULT_W       = 5;
    localparam int          PLL_SEL_BIT  = 5;
    localparam logic [23:0] BOOT_ADDR    = 24'h000000;
    localparam logic [5:0]  BOOT_RESET   = 6'h00;
    localparam logic [4:0]  MULT_MIN     = 5'h05;
    localparam logic [4:0]  MULT_MAX     = 5'h1f;
    localparam int          QUARTER_DIV  = 4;

    typedef enum logic {
        PSS_ARMED,
        PSS_LOCKED
    } pss_boot_state_t;

endpackage

// File: hdl/pss_quarter_div.sv
// Free-running divider: output level toggles to give clk/DIV.
// Assumes clk_i is the dot-rate clock; DIV must be a power of two of at least 2.
`timescale 1ns/1ns
module pss_quarter_div #(
    parameter int DIV = pss_pkg::QUARTER_DIV
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    output logic      div_clk_o
);

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : g_bad_div
        $error("DIV must be a power of two of at least 2");
    end

    assign next_count = count + CW'(1);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count     <= '0;
            div_clk_o <= 1'b0;
        end else begin
            count     <= next_count;
            div_clk_o <= next_count[CW-1];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    quarter_period_a: assert property (
        $past(arst_n_i, 4) |-> div_clk_o == $past(div_clk_o, DIV)
            && div_clk_o != $past(div_clk_o, DIV / 2))
        else $error("quarter clock period wrong");

endmodule // pss_quarter_div

// File: hdl/pss_boot_ctrl.sv
// Clock source and multiplier boot selection, written once per reset.
// Assumes host bus inputs are synchronous to clk_i, which runs at dot rate.
`timescale 1ns/1ns

module pss_boot_ctrl (
    input  wire logic                       clk_i,
    input  wire logic                       arst_n_i,
    input  wire logic [pss_pkg::BUS_W-1:0]  muxed_addr_data_bus_i,
    input  wire logic                       host_cs_n_i,
    input  wire logic                       host_rd_not_wr_i,
    input  wire logic                       host_addr_strobe_i,
    input  wire logic                       host_data_strobe_i,
    input  wire logic                       pixel_mode_direct_i,
    output logic                            boot_armed_o,
    output logic                            clk_src_pll_o,
    output logic [pss_pkg::MULT_W-1:0]      pll_mult_o,
    output logic                            mult_range_err_o,
    output logic                            free_run_quarter_clock_o
);

    pss_pkg::pss_boot_state_t    state;
    logic [pss_pkg::BUS_W-1:0]   addr_lat;
    logic [pss_pkg::BOOT_W-1:0]  pll_boot_config;
    logic                        boot_wr;
    logic                        next_pll_on;
    logic [pss_pkg::MULT_W-1:0]  cfg_mult;
    logic                        cfg_pll_sel;
    logic                        addr_seen;
    logic [1:0]                  since_rst;

    // Boot field layout must fit the six stored bits
    if (pss_pkg::PLL_SEL_BIT >= pss_pkg::BOOT_W
        || pss_pkg::MULT_LSB + pss_pkg::MULT_W > pss_pkg::BOOT_W
        || pss_pkg::BOOT_W > pss_pkg::BUS_W) begin : g_bad_layout
        $error("boot field layout does not fit the boot location");
    end

    // Address phase of a host cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_lat <= '0;
        end else if (host_addr_strobe_i && !host_cs_n_i) begin
            addr_lat <= muxed_addr_data_bus_i;
        end
    end

    // Cleared latch equals the boot address, so a data strobe
    // before any address phase must not reach the boot location
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_seen <= 1'b0;
        end else if (host_addr_strobe_i && !host_cs_n_i) begin
            addr_seen <= 1'b1;
        end
    end

    assign boot_wr = host_data_strobe_i && !host_cs_n_i && !host_rd_not_wr_i
                     && addr_seen && (addr_lat == pss_pkg::BOOT_ADDR)
                     && (state == pss_pkg::PSS_ARMED);

    // Arm at reset, lock on the first accepted write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state        <= pss_pkg::PSS_ARMED;
            boot_armed_o <= 1'b1;
        end else begin
            case (state)
                pss_pkg::PSS_ARMED: begin
                    if (boot_wr) begin
                        state        <= pss_pkg::PSS_LOCKED;
                        boot_armed_o <= 1'b0;
                    end
                end
                pss_pkg::PSS_LOCKED: begin
                    state        <= pss_pkg::PSS_LOCKED;
                    boot_armed_o <= 1'b0;
                end
                default: begin
                    state        <= pss_pkg::PSS_LOCKED;
                    boot_armed_o <= 1'b0;
                end
            endcase
        end
    end

    // Boot location storage
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pll_boot_config <= pss_pkg::BOOT_RESET;
        end else if (boot_wr) begin
            pll_boot_config <= muxed_addr_data_bus_i[pss_pkg::BOOT_W-1:0];
        end
    end

    assign cfg_mult    = pll_boot_config[pss_pkg::MULT_LSB +: pss_pkg::MULT_W];
    assign cfg_pll_sel = pll_boot_config[pss_pkg::PLL_SEL_BIT];
    assign next_pll_on = cfg_pll_sel && !pixel_mode_direct_i;

    // Clock source and multiplier to the loop macro
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_src_pll_o    <= 1'b0;
            pll_mult_o       <= '0;
            mult_range_err_o <= 1'b0;
        end else begin
            // Direct mode falls back to the pin clock
            clk_src_pll_o    <= next_pll_on;
            pll_mult_o       <= cfg_mult;
            // Flags a factor the loop is not meant to run with
            mult_range_err_o <= next_pll_on && (cfg_mult < pss_pkg::MULT_MIN
                                                || cfg_mult > pss_pkg::MULT_MAX);
        end
    end

    pss_quarter_div #(
        .DIV (pss_pkg::QUARTER_DIV)
    ) u_quarter (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .div_clk_o (free_run_quarter_clock_o)
    );

    // Edges since reset release, saturating; gates history-based checks
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            since_rst <= 2'h0;
        end else if (since_rst != 2'h3) begin
            since_rst <= since_rst + 2'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    write_needs_arm_a: assert property (
        $changed(pll_boot_config) |-> $past(state) == pss_pkg::PSS_ARMED && $past(boot_wr))
        else $error("boot location changed without armed write");

    locked_stays_a: assert property (
        state == pss_pkg::PSS_LOCKED |=> state == pss_pkg::PSS_LOCKED && $stable(pll_boot_config)[*3])
        else $error("boot location changed while locked");

    low_six_bits_a: assert property (
        boot_wr |=> pll_boot_config == $past(muxed_addr_data_bus_i[5:0]) && !boot_armed_o)
        else $error("boot write stored wrong bits");

    mult_follows_a: assert property (
        boot_wr |=> ##1 pll_mult_o == $past(muxed_addr_data_bus_i[4:0], 2))
        else $error("multiplier output not the written factor");

    pll_select_a: assert property (
        boot_wr && muxed_addr_data_bus_i[5] && !pixel_mode_direct_i ##1 !pixel_mode_direct_i
            |=> clk_src_pll_o)
        else $error("bit 5 did not select loop clocking");

    mode1_only_a: assert property (
        $past(pixel_mode_direct_i) |-> !clk_src_pll_o)
        else $error("loop clocking in direct colour mode");

    range_flag_a: assert property (
        mult_range_err_o |-> clk_src_pll_o && pll_mult_o < 5'h05)
        else $error("range flag without low factor");

    cleared_default_a: assert property (
        state == pss_pkg::PSS_ARMED |-> pll_boot_config == 6'h00 && !clk_src_pll_o && pll_mult_o == 5'h00)
        else $error("not direct clocking before boot write");

    armed_first_a: assert property (
        since_rst == 2'h0 |-> boot_armed_o && state == pss_pkg::PSS_ARMED)
        else $error("boot location not armed after reset");

    armed_matches_a: assert property (
        boot_armed_o == (state == pss_pkg::PSS_ARMED))
        else $error("armed output disagrees with boot state");

    bare_strobe_a: assert property (
        !addr_seen |-> !boot_wr)
        else $error("boot write taken without address phase");

    locked_write_a: assert property (
        state == pss_pkg::PSS_LOCKED && host_data_strobe_i && !host_cs_n_i && !host_rd_not_wr_i
            |=> $stable(pll_boot_config) && !boot_armed_o)
        else $error("write accepted while locked");

    direct_default_a: assert property (
        !$past(cfg_pll_sel) |-> !clk_src_pll_o)
        else $error("loop clocking without bit 5");

    factor_passed_a: assert property (
        pll_mult_o == $past(cfg_mult))
        else $error("loop factor not the stored factor");

    range_low_a: assert property (
        clk_src_pll_o && pll_mult_o < pss_pkg::MULT_MIN |-> mult_range_err_o)
        else $error("low factor in loop mode not flagged");

    quarter_phase_a: assert property (
        since_rst == 2'h1 |-> !free_run_quarter_clock_o)
        else $error("quarter clock phase wrong after reset");

    quarter_free_run_a: assert property (
        since_rst == 2'h3 |-> free_run_quarter_clock_o != $past(free_run_quarter_clock_o, 2))
        else $error("quarter clock stopped or wrong rate");

    boot_write_c:    cover property (boot_wr);
    ignored_write_c: cover property (state == pss_pkg::PSS_LOCKED && host_data_strobe_i
                                     && !host_cs_n_i && !host_rd_not_wr_i);
    pll_on_c:        cover property (clk_src_pll_o && pll_mult_o >= 5'h05);
    mode_drop_c:     cover property (clk_src_pll_o ##1 !clk_src_pll_o);
    range_err_c:     cover property (mult_range_err_o);

endmodule // pss_boot_ctrl

// File: bench/pss_host_model.sv
// Host processor model driving the multiplexed address/data bus.
// Assumes the bench calls cycle() from one process; drives on falling edges.
`timescale 1ns/1ns
module pss_host_model (
    input  wire logic        clk_i,
    output logic [23:0]      bus_o,
    output logic             cs_n_o,
    output logic             rd_not_wr_o,
    output logic             as_o,
    output logic             ds_o
);
    initial begin
        bus_o       = 24'h5a5a5a;
        cs_n_o      = 1'b1;
        rd_not_wr_o = 1'b1;
        as_o        = 1'b0;
        ds_o        = 1'b0;
    end

    // Address phase, then data phase, then release
    task automatic cycle(input logic [23:0] addr, input logic [23:0] data, input logic rd);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        as_o   = 1'b1;
        bus_o  = addr;
        @(negedge clk_i);
        as_o        = 1'b0;
        ds_o        = 1'b1;
        rd_not_wr_o = rd;
        bus_o       = data;
        @(negedge clk_i);
        ds_o   = 1'b0;
        cs_n_o = 1'b1;
        bus_o  = ~bus_o; // Released bus shows no stale value
    endtask
endmodule // pss_host_model

// File: bench/pll_speed_select_boot_tb_top.sv
// Self-checking bench for the boot selection block.
// Assumes the host model in pss_host_model.sv.
`timescale 1ns/1ns
module pll_speed_select_boot_tb_top;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        mode = 1'b0;
    logic [23:0] bus;
    logic        cs_n, rnw, as, ds, armed, pll, err, qclk;
    logic [4:0]  mult;
    logic [7:0]  st;
    int          miscompares = 0;
    int          comparisons = 0;

    always #2 clk = ~clk;
    assign st = {armed, pll, err, mult};

    pss_host_model host (.clk_i(clk), .bus_o(bus), .cs_n_o(cs_n), .rd_not_wr_o(rnw), .as_o(as), .ds_o(ds));
    pss_boot_ctrl DUT (.clk_i(clk), .arst_n_i(arst_n), .muxed_addr_data_bus_i(bus), .host_cs_n_i(cs_n),
        .host_rd_not_wr_i(rnw), .host_addr_strobe_i(as), .host_data_strobe_i(ds),
        .pixel_mode_direct_i(mode), .boot_armed_o(armed), .clk_src_pll_o(pll), .pll_mult_o(mult),
        .mult_range_err_o(err), .free_run_quarter_clock_o(qclk));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        @(negedge clk);
        arst_n = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
    endtask

    task automatic t_boot_lock();
        do_reset();
        chk("reset state", 8'h80, st);
        host.cycle(pss_pkg::BOOT_ADDR, 24'hffffea, 1'b0);
        repeat (2) @(negedge clk);
        chk("boot write", 8'h4a, st);
        host.cycle(pss_pkg::BOOT_ADDR, 24'h00003f, 1'b0);
        repeat (2) @(negedge clk);
        chk("second write", 8'h4a, st);
        mode = 1'b1;
        repeat (2) @(negedge clk);
        chk("direct mode", 8'h0a, st);
        mode = 1'b0;
        repeat (2) @(negedge clk);
        chk("palette mode", 8'h4a, st);
        $display("test boot_lock done");
    endtask

    task automatic t_refused();
        do_reset();
        host.cycle(24'h000004, 24'h000025, 1'b0);
        host.cycle(pss_pkg::BOOT_ADDR, 24'h000025, 1'b1);
        repeat (2) @(negedge clk);
        chk("other cycles", 8'h80, st);
        host.cycle(pss_pkg::BOOT_ADDR, 24'h000025, 1'b0);
        repeat (2) @(negedge clk);
        chk("armed write", 8'h45, st);
        $display("test refused done");
    endtask

    task automatic t_values();
        logic [5:0] vals [5];
        logic [7:0] exp;
        vals = '{6'h11, 6'h25, 6'h3f, 6'h23, 6'h00};
        foreach (vals[i]) begin
            do_reset();
            host.cycle(pss_pkg::BOOT_ADDR, {18'h2aaaa, vals[i]}, 1'b0);
            repeat (2) @(negedge clk);
            exp = {1'b0, vals[i][5], vals[i][5] && (vals[i][4:0] < pss_pkg::MULT_MIN), vals[i][4:0]};
            chk("boot value", exp, st);
        end
        $display("test values done");
    endtask

    task automatic t_quarter();
        logic [11:0] qs;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk);
            qs[i] = qclk;
        end
        for (int i = 0; i < 10; i++) begin
            chk("quarter clock", {7'h00, ~qs[i]}, {7'h00, qs[i+2]});
        end
        $display("test quarter done");
    endtask

    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #40000;
        miscompares++;
        final_report();
    end

    initial begin
        t_boot_lock();
        t_refused();
        t_values();
        t_quarter();
        final_report();
    end
endmodule // pll_speed_select_boot_tb_top
